// File: hw/fsap_pkg.sv
// Package for the buffer status and asynchronous port block
// Assumes a 32-bit AHB-Lite register bus and a single 100 MHz clock
package fsap_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] FSAP_OFS_STATUS = 8'h64;
  localparam logic [7:0] FSAP_OFS_TXCTL = 8'h68;
  localparam logic [7:0] FSAP_OFS_RXCTL = 8'h6C;
  localparam logic [31:0] FSAP_RST_STATUS = 32'h0055_0000;
  localparam logic [31:0] FSAP_RST_CTL = 32'h0000_0000;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FSAP_B_ATX_EMPTY = 16;
  localparam int FSAP_B_ATX_FULL = 17;
  localparam int FSAP_B_ARX_EMPTY = 18;
  localparam int FSAP_B_ITX_EMPTY = 20;
  localparam int FSAP_B_ITX_FULL = 21;
  localparam int FSAP_B_IRX_EMPTY = 22;
  localparam int FSAP_B_HOST_LE = 24;
  localparam int FSAP_B_DMA_LE = 27;
  localparam int FSAP_B_SEL_LO = 28;
  localparam int FSAP_B_REQ_EN = 30;
  localparam int FSAP_B_ACK_EN = 31;
  localparam int FSAP_B_EN = 31;
  localparam int FSAP_B_CAUSE_LO = 28;
  localparam int FSAP_B_PROG_LO = 16;
  localparam int FSAP_LEN_W = 11;
  localparam logic [10:0] FSAP_STEP = 11'h002;
  // ************************************************************
  // Stop causes
  // ************************************************************
  localparam logic [1:0] FSAP_CAUSE_SW = 2'h0;
  localparam logic [1:0] FSAP_CAUSE_LEN = 2'h1;
  localparam logic [1:0] FSAP_CAUSE_CLR = 2'h2;
  localparam logic [1:0] FSAP_CAUSE_EXT = 2'h3;
  typedef struct packed {
    logic atx_empty;
    logic atx_full;
    logic arx_empty;
    logic itx_empty;
    logic itx_full;
    logic irx_empty;
  } fsap_flags_s;
  typedef struct packed {
    logic en;
    logic [1:0] cause;
    logic [10:0] progress;
    logic [10:0] length;
  } fsap_port_s;
endpackage

// File: hw/fsap_port_ctl.sv
// One direction of the asynchronous port: enable, length, progress, cause
// Assumes strobes and stop inputs are synchronous one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module fsap_port_ctl
  import fsap_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  input wire logic i_step,
  input wire logic i_buf_clear,
  input wire logic i_ext_stop,
  output fsap_port_s o_state
);
  fsap_port_s st_q;
  fsap_port_s st_d;
  logic [10:0] prog_inc;
  logic hit_len;
  logic start;
  assign start = i_wr & i_wdata[FSAP_B_EN] & ~st_q.en;
  assign prog_inc = st_q.progress + FSAP_STEP;
  // Stop exactly when this step lands on the length
  assign hit_len = i_step & st_q.en & (prog_inc == st_q.length);
  always_comb begin
    st_d = st_q;
    if (i_wr) begin
      st_d.length = {i_wdata[10:2], 2'h0};
      st_d.en = i_wdata[FSAP_B_EN];
      if (st_q.en & ~i_wdata[FSAP_B_EN]) begin
        st_d.cause = FSAP_CAUSE_SW;
      end
    end
    if (start) begin
      st_d.progress = 11'h000;
    end else if (i_step & st_q.en) begin
      st_d.progress = {prog_inc[10:1], 1'b0};
    end
    // A buffer clear wins over any software write in the same cycle; end and length stops only win while already enabled
    if (st_q.en | start) begin
      if (i_buf_clear) begin
        st_d.en = 1'b0;
        st_d.cause = FSAP_CAUSE_CLR;
      end else if (i_ext_stop & st_q.en) begin
        st_d.en = 1'b0;
        st_d.cause = FSAP_CAUSE_EXT;
      end else if (hit_len) begin
        st_d.en = 1'b0;
        st_d.cause = FSAP_CAUSE_LEN;
      end
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_state = st_q;
  property p_step_len;
    @(posedge i_clock) disable iff (!i_rst_n)
      hit_len & ~i_buf_clear & ~i_ext_stop & ~i_wr |=> !st_q.en && st_q.cause == FSAP_CAUSE_LEN;
  endproperty
  a_step_len: assert property (p_step_len) else $error("length stop not taken");
  property p_prog_even;
    @(posedge i_clock) disable iff (!i_rst_n)
      st_q.progress[0] == 1'b0 && st_q.length[1:0] == 2'h0;
  endproperty
  a_prog_even: assert property (p_prog_even) else $error("fixed low bits not zero");
endmodule // fsap_port_ctl
`default_nettype wire

// File: hw/fsap_top.sv
// Buffer status, DMA request control and asynchronous port control
// Assumes AHB-Lite single-word accesses and buffer flags from the engines
//
// Summary of operation
// - Iso receive fill bytes, low bits zero
// - Capture fill size at read strobe fall
// - Bits 16/17 show async tx empty/full
// - Bit 18 shows async rx empty
// - Bits 20/21 show iso tx empty/full
// - Bit 22 shows iso rx empty
// - Bit 24 selects host byte order
// - Bit 27 selects DMA byte order
// - Bits 28-29 pick the DMA request flag
// - Bit 30 gates the DMA request line
// - Bit 31 gates the DMA acknowledge input
// - Tx length in bits 10-0, quadlet aligned
// - Tx progress clears, steps two per strobe
// - Tx enable drives port, stops on end/length
// - Tx stop cause recorded in bits 29-28
// - Rx length in bits 0-10, quadlet aligned
// - Rx progress clears, steps two per strobe
// - Rx stop cause recorded in bits 29-28
// - Packet ready while enabled with stored packet
`timescale 1ns/100ps
`default_nettype none
module fsap_top
  import fsap_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire fsap_flags_s i_flags,
  input wire logic i_iso_is_rx,
  input wire logic [15:0] i_iso_rx_fill_bytes,
  input wire logic i_host_rd_n,
  input wire logic i_rx_packet_stored,
  input wire logic i_async_tx_buf_clear,
  input wire logic i_async_rx_buf_clear,
  input wire logic i_dma_ack_n,
  output logic o_dma_req,
  output logic o_dma_ack,
  output logic o_host_little,
  output logic o_dma_little,
  input wire logic i_port_tx_write_strobe_n,
  input wire logic i_port_rx_read_strobe_n,
  input wire logic i_port_tx_end_n,
  output logic o_port_tx_active_n,
  output logic o_port_rx_packet_ready_n,
  output logic o_port_tx_push,
  output logic o_port_rx_pop
);
  // ************************************************************
  // Bus slave
  // ************************************************************
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic [7:0] ctl_q;
  logic rd_n_q;
  logic [15:0] fill_q;
  logic take;
  logic wr_status;
  logic wr_tx;
  logic wr_rx;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  fsap_port_s tx_st;
  fsap_port_s rx_st;
  assign take = i_hsel & i_hready & i_htrans[1];
  // Writes land one cycle after the address phase, with hwdata
  assign wr_status = wr_pend_q & (addr_q == FSAP_OFS_STATUS);
  assign wr_tx = wr_pend_q & (addr_q == FSAP_OFS_TXCTL);
  assign wr_rx = wr_pend_q & (addr_q == FSAP_OFS_RXCTL);
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_q;
  function automatic logic [31:0] port_word(input fsap_port_s s);
    port_word = {s.en, 1'b0, s.cause, 1'b0, s.progress, 5'h00, s.length};
  endfunction
  // ************************************************************
  // Status word
  // ************************************************************
  // Fill size frozen at the read strobe fall so a slow read sees one value
  assign status_word = {ctl_q[7:4], ctl_q[3], 2'h0, ctl_q[0], 1'b0,
    i_flags.irx_empty, i_flags.itx_full, i_flags.itx_empty, 1'b0,
    i_flags.arx_empty, i_flags.atx_full, i_flags.atx_empty,
    fill_q};
  assign rd_word = (i_haddr[7:0] == FSAP_OFS_STATUS) ? status_word :
    (i_haddr[7:0] == FSAP_OFS_TXCTL) ? port_word(tx_st) :
    (i_haddr[7:0] == FSAP_OFS_RXCTL) ? port_word(rx_st) : 32'h0000_0000;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= take & i_hwrite;
      addr_q <= i_haddr[7:0];
      rdata_q <= (take & ~i_hwrite) ? rd_word : rdata_q;
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctl_q <= 8'h00;
    end else if (wr_status) begin
      ctl_q <= {i_hwdata[31:27], 2'h0, i_hwdata[FSAP_B_HOST_LE]};
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rd_n_q <= 1'b1;
      fill_q <= 16'h0000;
    end else begin
      rd_n_q <= i_host_rd_n;
      if (rd_n_q & ~i_host_rd_n) begin
        fill_q <= i_iso_is_rx ? {i_iso_rx_fill_bytes[15:2], 2'h0} : 16'h0000;
      end
    end
  end
  // ************************************************************
  // DMA request and acknowledge
  // ************************************************************
  logic [3:0] req_src;
  logic req_pick;
  assign req_src = {i_flags.irx_empty, i_flags.itx_full, i_flags.arx_empty, i_flags.atx_full};
  assign req_pick = req_src[ctl_q[5:4]];
  assign o_dma_req = ctl_q[6] & req_pick;
  assign o_dma_ack = ctl_q[7] & ~i_dma_ack_n;
  assign o_host_little = ctl_q[0];
  assign o_dma_little = ctl_q[3];
  // ************************************************************
  // Asynchronous port
  // ************************************************************
  // Software is expected to write the lower part first, so enable comes last
  // with the length already in place; full-word writes are used here
  logic tx_step;
  logic rx_step;
  assign tx_step = ~i_port_tx_write_strobe_n & tx_st.en;
  assign rx_step = ~i_port_rx_read_strobe_n & rx_st.en;
  assign o_port_tx_push = tx_step;
  assign o_port_rx_pop = rx_step;
  fsap_port_ctl u_tx (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_wr(wr_tx),
    .i_wdata(i_hwdata),
    .i_step(tx_step),
    .i_buf_clear(i_async_tx_buf_clear),
    .i_ext_stop(~i_port_tx_end_n),
    .o_state(tx_st)
  );
  fsap_port_ctl u_rx (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_wr(wr_rx),
    .i_wdata(i_hwdata),
    .i_step(rx_step),
    .i_buf_clear(i_async_rx_buf_clear),
    .i_ext_stop(i_flags.arx_empty),
    .o_state(rx_st)
  );
  assign o_port_tx_active_n = ~tx_st.en;
  assign o_port_rx_packet_ready_n = ~(rx_st.en & i_rx_packet_stored);
  // ************************************************************
  // Checks
  // ************************************************************
  property p_req_gate;
    @(posedge i_clock) disable iff (!i_rst_n) !ctl_q[7 - 1] |-> !o_dma_req;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("dma request while off");
  property p_req_sel;
    @(posedge i_clock) disable iff (!i_rst_n)
      ctl_q[6] && ctl_q[5:4] == 2'h1 |-> o_dma_req == i_flags.arx_empty;
  endproperty
  a_req_sel: assert property (p_req_sel) else $error("wrong request source");
  property p_ack_gate;
    @(posedge i_clock) disable iff (!i_rst_n) !ctl_q[7] |-> !o_dma_ack;
  endproperty
  a_ack_gate: assert property (p_ack_gate) else $error("ack honoured while off");
  property p_tx_pin;
    @(posedge i_clock) disable iff (!i_rst_n) o_port_tx_active_n == !tx_st.en;
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("tx enable pin mismatch");
  property p_tx_ext;
    @(posedge i_clock) disable iff (!i_rst_n)
      tx_st.en && !i_port_tx_end_n && !i_async_tx_buf_clear |=>
      !tx_st.en && tx_st.cause == FSAP_CAUSE_EXT;
  endproperty
  a_tx_ext: assert property (p_tx_ext) else $error("end input did not stop tx");
  property p_rx_clr;
    @(posedge i_clock) disable iff (!i_rst_n)
      rx_st.en && i_async_rx_buf_clear |=> !rx_st.en && rx_st.cause == FSAP_CAUSE_CLR;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx clear cause lost");
  property p_tx_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
      !tx_st.en && !wr_tx |=> $stable(tx_st.progress);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("progress moved while off");
  property p_tx_count;
    @(posedge i_clock) disable iff (!i_rst_n)
      tx_step && !wr_tx |=> tx_st.progress == $past(tx_st.progress) + FSAP_STEP;
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("tx progress step wrong");
  property p_fill_tx;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_n_q && !i_host_rd_n && !i_iso_is_rx |=> fill_q == 16'h0000;
  endproperty
  a_fill_tx: assert property (p_fill_tx) else $error("fill size not zero on tx");
  property p_pkt;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_port_rx_packet_ready_n == !(rx_st.en && i_rx_packet_stored);
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet ready wrong");
  // Read qualifiers for the checks below; read data shows one edge later
  logic rd_stat;
  logic rd_tx;
  assign rd_stat = take & ~i_hwrite & (i_haddr[7:0] == FSAP_OFS_STATUS);
  assign rd_tx = take & ~i_hwrite & (i_haddr[7:0] == FSAP_OFS_TXCTL);
  property p_st_atx;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_stat |=> o_hrdata[17:16] == {$past(i_flags.atx_full), $past(i_flags.atx_empty)};
  endproperty
  a_st_atx: assert property (p_st_atx) else $error("async tx flags wrong");
  property p_st_arx;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_stat |=> o_hrdata[18] == $past(i_flags.arx_empty);
  endproperty
  a_st_arx: assert property (p_st_arx) else $error("async rx flag wrong");
  property p_st_itx;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_stat |=> o_hrdata[21:20] == {$past(i_flags.itx_full), $past(i_flags.itx_empty)};
  endproperty
  a_st_itx: assert property (p_st_itx) else $error("iso tx flags wrong");
  property p_st_irx;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_stat |=> o_hrdata[22] == $past(i_flags.irx_empty);
  endproperty
  a_st_irx: assert property (p_st_irx) else $error("iso rx flag wrong");
  property p_st_fill;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_stat |=> o_hrdata[15:0] == $past(fill_q);
  endproperty
  a_st_fill: assert property (p_st_fill) else $error("fill size not read");
  property p_fill_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
      !(rd_n_q && !i_host_rd_n) |=> $stable(fill_q);
  endproperty
  a_fill_hold: assert property (p_fill_hold) else $error("fill size moved");
  property p_fill_cap;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_n_q && !i_host_rd_n && i_iso_is_rx |=>
      fill_q == {$past(i_iso_rx_fill_bytes[15:2]), 2'h0};
  endproperty
  a_fill_cap: assert property (p_fill_cap) else $error("fill size not captured");
  property p_host_le;
    @(posedge i_clock) disable iff (!i_rst_n)
      wr_status |=> o_host_little == $past(i_hwdata[FSAP_B_HOST_LE]);
  endproperty
  a_host_le: assert property (p_host_le) else $error("host order not taken");
  property p_dma_le;
    @(posedge i_clock) disable iff (!i_rst_n)
      wr_status |=> o_dma_little == $past(i_hwdata[FSAP_B_DMA_LE]);
  endproperty
  a_dma_le: assert property (p_dma_le) else $error("dma order not taken");
  property p_req_atx;
    @(posedge i_clock) disable iff (!i_rst_n)
      ctl_q[6] && ctl_q[5:4] == 2'h0 |-> o_dma_req == i_flags.atx_full;
  endproperty
  a_req_atx: assert property (p_req_atx) else $error("request not tx full");
  property p_req_itx;
    @(posedge i_clock) disable iff (!i_rst_n)
      ctl_q[6] && ctl_q[5:4] == 2'h2 |-> o_dma_req == i_flags.itx_full;
  endproperty
  a_req_itx: assert property (p_req_itx) else $error("request not iso full");
  property p_req_irx;
    @(posedge i_clock) disable iff (!i_rst_n)
      ctl_q[6] && ctl_q[5:4] == 2'h3 |-> o_dma_req == i_flags.irx_empty;
  endproperty
  a_req_irx: assert property (p_req_irx) else $error("request not iso empty");
  property p_ack_on;
    @(posedge i_clock) disable iff (!i_rst_n)
      ctl_q[7] |-> o_dma_ack == !i_dma_ack_n;
  endproperty
  a_ack_on: assert property (p_ack_on) else $error("ack not honoured");
  property p_tx_sw;
    @(posedge i_clock) disable iff (!i_rst_n)
      wr_tx && !i_hwdata[FSAP_B_EN] && tx_st.en && !i_async_tx_buf_clear && i_port_tx_end_n &&
      i_port_tx_write_strobe_n |=> !tx_st.en && tx_st.cause == FSAP_CAUSE_SW;
  endproperty
  a_tx_sw: assert property (p_tx_sw) else $error("tx software stop lost");
  property p_tx_clr;
    @(posedge i_clock) disable iff (!i_rst_n)
      tx_st.en && i_async_tx_buf_clear |=> !tx_st.en && tx_st.cause == FSAP_CAUSE_CLR;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx clear cause lost");
  property p_rx_ext;
    @(posedge i_clock) disable iff (!i_rst_n)
      rx_st.en && i_flags.arx_empty && !i_async_rx_buf_clear |=>
      !rx_st.en && rx_st.cause == FSAP_CAUSE_EXT;
  endproperty
  a_rx_ext: assert property (p_rx_ext) else $error("rx empty stop lost");
  property p_rx_sw;
    @(posedge i_clock) disable iff (!i_rst_n)
      wr_rx && !i_hwdata[FSAP_B_EN] && rx_st.en && !i_async_rx_buf_clear && !i_flags.arx_empty &&
      i_port_rx_read_strobe_n |=> !rx_st.en && rx_st.cause == FSAP_CAUSE_SW;
  endproperty
  a_rx_sw: assert property (p_rx_sw) else $error("rx software stop lost");
  property p_tx_start;
    @(posedge i_clock) disable iff (!i_rst_n)
      wr_tx && i_hwdata[FSAP_B_EN] && !tx_st.en && !i_async_tx_buf_clear |=>
      tx_st.en && tx_st.progress == 11'h000;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start not clean");
  property p_rx_start;
    @(posedge i_clock) disable iff (!i_rst_n)
      wr_rx && i_hwdata[FSAP_B_EN] && !rx_st.en && !i_async_rx_buf_clear |=>
      rx_st.en && rx_st.progress == 11'h000;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("rx start not clean");
  property p_rx_count;
    @(posedge i_clock) disable iff (!i_rst_n)
      rx_step && !wr_rx |=> rx_st.progress == $past(rx_st.progress) + FSAP_STEP;
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("rx progress step wrong");
  property p_rd_tx;
    @(posedge i_clock) disable iff (!i_rst_n)
      rd_tx |=> o_hrdata[10:0] == $past(tx_st.length) &&
      o_hrdata[26:16] == $past(tx_st.progress);
  endproperty
  a_rd_tx: assert property (p_rd_tx) else $error("tx control read wrong");
  property p_rx_len;
    @(posedge i_clock) disable iff (!i_rst_n)
      rx_step && !wr_rx && !i_async_rx_buf_clear && !i_flags.arx_empty &&
      rx_st.progress + FSAP_STEP == rx_st.length |=> !rx_st.en && rx_st.cause == FSAP_CAUSE_LEN;
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("rx length stop lost");
endmodule // fsap_top
`default_nettype wire

// File: tb/fsap_far_model.sv
// Far-side model of the asynchronous port: write/read strobes and end-of-transfer
// Assumes its tasks are entered right after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module fsap_far_model (
  input wire logic i_clock,
  output logic o_tx_strobe_n,
  output logic o_rx_strobe_n,
  output logic o_end_n
);
  // ************************************************************
  // Strobe bursts, prompt (gap 0, strobe held low) or slow
  // ************************************************************
  initial begin
    o_tx_strobe_n = 1'b1;
    o_rx_strobe_n = 1'b1;
    o_end_n = 1'b1;
  end
  task automatic drive(input int d, input logic v);
    if (d != 0) o_rx_strobe_n <= v;
    else o_tx_strobe_n <= v;
  endtask
  task automatic burst(input int d, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      drive(d, 1'b0);
      @(posedge i_clock);
      // Held low between steps when prompt, so the line is never written twice a step
      if (gap > 0 || i == n - 1) begin
        drive(d, 1'b1);
        repeat (gap) @(posedge i_clock);
      end
    end
  endtask
  task automatic end_pulse;
    o_end_n <= 1'b0;
    @(posedge i_clock);
    o_end_n <= 1'b1;
  endtask
endmodule // fsap_far_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the buffer status and asynchronous port block
// Assumes the far-side model drives the port strobes; one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top
  import fsap_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, iso_rx, rd_n, pkt, tclr, rclr, ack_n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rnd, rd, ctl;
  logic [15:0] fill;
  fsap_flags_s flags;
  logic dma_req, dma_ack, host_le, dma_le, tx_n, rx_n, end_n, tx_act_n, rdy_n, push, pop;
  int n_fail = 0;
  int samples_checked = 0;
  int n_push = 0;
  int n_pop = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    n_push <= n_push + int'(push === 1'b1);
    n_pop <= n_pop + int'(pop === 1'b1);
  end
  fsap_far_model far (.i_clock(clk), .o_tx_strobe_n(tx_n), .o_rx_strobe_n(rx_n),
    .o_end_n(end_n));
  fsap_top uut (.i_clock(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_flags(flags), .i_iso_is_rx(iso_rx), .i_iso_rx_fill_bytes(fill), .i_host_rd_n(rd_n),
    .i_rx_packet_stored(pkt), .i_async_tx_buf_clear(tclr), .i_async_rx_buf_clear(rclr),
    .i_dma_ack_n(ack_n), .o_dma_req(dma_req), .o_dma_ack(dma_ack), .o_host_little(host_le),
    .o_dma_little(dma_le), .i_port_tx_write_strobe_n(tx_n), .i_port_rx_read_strobe_n(rx_n),
    .i_port_tx_end_n(end_n), .o_port_tx_active_n(tx_act_n),
    .o_port_rx_packet_ready_n(rdy_n), .o_port_tx_push(push), .o_port_rx_pop(pop));
  // ************************************************************
  // Expectations, random source and bus cycles
  // ************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_stat(input logic [31:0] c, input fsap_flags_s f);
    return (c & 32'hF9000000) | {9'h000, f.irx_empty, f.itx_full, f.itx_empty, 1'b0,
      f.arx_empty, f.atx_full, f.atx_empty, 16'h0000};
  endfunction
  function automatic logic exp_req(input logic [31:0] c, input fsap_flags_s f);
    logic [3:0] src;
    src = {f.irx_empty, f.itx_full, f.arx_empty, f.atx_full};
    return c[30] & src[c[29:28]];
  endfunction
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k >= 50) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Whole words only, so the narrow high-first write order never arises
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rdat);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdat = hrdata;
  endtask
  // One port run: d picks direction, s picks the stop cause to provoke
  task automatic port_run(input int d, input int s);
    logic [31:0] a;
    logic [10:0] len;
    int n, g, c0;
    rnd = nxt(rnd);
    a = (d != 0) ? 32'h0000006C : 32'h00000068;
    n = 1 + int'(rnd[2:0]);
    g = int'(rnd[4:3]) % 3;
    len = (s == 1) ? 11'(4 * n) : 11'h7FF;
    if (s == 1) n = 2 * n;
    c0 = (d != 0) ? n_pop : n_push;
    bus(1'b1, a, {1'b1, 20'h00000, len}, rd);
    #1;
    `CHK((d != 0) ? rdy_n : tx_act_n, 1'b0)
    @(posedge clk);
    far.burst(d, n, g);
    if (s == 0) bus(1'b1, a, {1'b0, 20'h00000, len}, rd);
    if (s == 2) begin
      if (d != 0) rclr <= 1'b1;
      else tclr <= 1'b1;
      @(posedge clk);
      rclr <= 1'b0;
      tclr <= 1'b0;
    end
    if (s == 3 && d == 0) far.end_pulse();
    if (s == 3 && d != 0) begin
      flags.arx_empty <= 1'b1;
      @(posedge clk);
      flags.arx_empty <= 1'b0;
    end
    @(posedge clk);
    `CHK((d != 0) ? rdy_n : tx_act_n, 1'b1)
    far.burst(d, 1, 1);
    `CHK(((d != 0) ? n_pop : n_push) - c0, n)
    bus(1'b0, a, 32'h0, rd);
    `CHK(rd, {2'b00, 2'(s), 1'b0, 11'(2 * n), 5'h00, len & 11'h7FC})
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    flags = 6'h2D;
    rnd = 32'h0000004E;
    {iso_rx, fill, pkt, tclr, rclr} = '0;
    rd_n = 1'b1;
    ack_n = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK({dma_req, tx_act_n, rdy_n, hresp}, 4'h6)
    bus(1'b1, 32'h00000070, 32'hFFFFFFFF, rd);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 32'h00000064 + 32'(4 * i), 32'h0, rd);
      `CHK(rd, (i == 0) ? FSAP_RST_STATUS : FSAP_RST_CTL)
    end
    for (int i = 0; i < 24; i++) begin
      rnd = nxt(rnd);
      ctl = {rnd[31:30], 2'(i), rnd[27:0]};
      flags <= rnd[5:0];
      ack_n <= rnd[6];
      bus(1'b1, 32'h00000064, ctl, rd);
      bus(1'b0, 32'h00000064, 32'h0, rd);
      `CHK(rd, exp_stat(ctl, flags))
      `CHK(dma_req, exp_req(ctl, flags))
      `CHK(dma_ack, ctl[31] & ~ack_n)
      `CHK({host_le, dma_le}, {ctl[24], ctl[27]})
    end
    // Size is changed while the strobe is still low to prove it was latched
    rnd = nxt(rnd);
    iso_rx <= 1'b1;
    fill <= rnd[15:0] & 16'hFFFC;
    rd_n <= 1'b0;
    repeat (3) @(posedge clk);
    fill <= ~rnd[15:0] & 16'hFFFC;
    @(posedge clk);
    rd_n <= 1'b1;
    bus(1'b0, 32'h00000064, 32'h0, rd);
    `CHK(rd[15:0], rnd[15:0] & 16'hFFFC)
    iso_rx <= 1'b0;
    rd_n <= 1'b0;
    @(posedge clk);
    rd_n <= 1'b1;
    bus(1'b0, 32'h00000064, 32'h0, rd);
    `CHK(rd[15:0], 16'h0000)
    flags <= 6'h00;
    pkt <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 4; s++) begin
        port_run(d, s);
      end
    end
    print_verdict();
  end
endmodule // tb_top
`undef CHK
`default_nettype wire
